// [core/ptc_cond.sv]
// module: program-table input conditioning with apb settings and serial command port
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module ptc_cond #(
  parameter int unsigned SEL_COUNT = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ptc_pkg::PTC_ADDR_W-1:0] paddr,
  input wire logic [ptc_pkg::PTC_DATA_W-1:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [ptc_pkg::PTC_DATA_W-1:0] prdata,
  // contact inputs, high means contact closed
  input wire logic mode_select_in,
  input wire logic run_halt_in,
  input wire logic sequence_cancel_in,
  input wire logic [SEL_COUNT-1:0] step_select_in,
  // conditioned outputs
  output logic program_mode,
  output logic sequence_run,
  output logic sequence_cancel_pulse,
  output logic [ptc_pkg::PTC_STEP_W-1:0] sequence_step_number
);
  import ptc_pkg::*;

  typedef struct packed {
    logic [PTC_CFG_W-1:0] cfg_shadow;
    logic [PTC_SELPOL_W-1:0] selpol_shadow;
    logic [PTC_CFG_W-1:0] cfg_act;
    logic [PTC_SELPOL_W-1:0] selpol_act;
    logic cancel_prev;
    logic primed;
    logic serial_own;
    logic serial_run;
    logic serial_step_vld;
    logic [PTC_STEP_W-1:0] serial_step;
    logic mode0;
    logic run;
    logic cancel_pulse;
    logic [PTC_STEP_W-1:0] step;
    logic pready;
    logic pslverr;
    logic [PTC_DATA_W-1:0] prdata;
  } ptc_state_t;

  ptc_state_t st_ff;
  ptc_state_t nxt_st;

  // =====================================================================
  // elaboration checks
  if (SEL_COUNT < 1 || SEL_COUNT > PTC_STEP_W) begin : g_bad_sel
    $error("ptc_cond supports one to eight select inputs");
  end
  if (PTC_RAW_W != PTC_STEP_W + 3) begin : g_bad_raw
    $error("ptc_cond needs the raw bus to hold the three contacts and every select");
  end
  if (PTC_SELPOL_W < 2 * PTC_STEP_W) begin : g_bad_selpol
    $error("ptc_cond needs two setting bits for each select input");
  end

  // =====================================================================
  // setting decode shared by mode and select inputs
  function automatic logic pol_level(input logic [1:0] pol, input logic contact);
    logic lvl;
    lvl = 1'b0;
    unique case (pol)
      PTC_POL_CLOSED: lvl = contact;
      PTC_POL_OPEN: lvl = ~contact;
      PTC_POL_FORCE_ON: lvl = 1'b1;
      PTC_POL_FORCE_OFF: lvl = 1'b0;
    endcase
    return lvl;
  endfunction

  // =====================================================================
  // synchroniser for every contact before any decoding
  ptc_sync_if #(.WIDTH(PTC_RAW_W)) sif ();

  logic [PTC_STEP_W-1:0] sel_pad;
  always_comb begin
    sel_pad = '0;
    sel_pad[SEL_COUNT-1:0] = step_select_in;
  end

  // every contact passes the same two flops, so mode, run and step outputs stay aligned
  assign sif.raw = {sel_pad, sequence_cancel_in, run_halt_in, mode_select_in};

  ptc_sync #(
    .WIDTH(PTC_RAW_W),
    .STAGES(PTC_SYNC_STAGES)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .sif(sif)
  );

  // =====================================================================
  // clean levels and active settings
  logic mode_c;
  logic run_c;
  logic cancel_c;
  logic [PTC_STEP_W-1:0] sel_c;
  logic [1:0] mode_pol;
  logic [1:0] run_pol;
  logic [1:0] cancel_pol;

  assign mode_c = sif.clean[0];
  assign run_c = sif.clean[1];
  assign cancel_c = sif.clean[2];
  assign sel_c = sif.clean[PTC_RAW_W-1:3];
  assign mode_pol = st_ff.cfg_act[PTC_CFG_MODE_POS +: 2];
  assign run_pol = st_ff.cfg_act[PTC_CFG_RUN_POS +: 2];
  assign cancel_pol = st_ff.cfg_act[PTC_CFG_CANCEL_POS +: 2];

  // =====================================================================
  // one-hot register decode, shared by the write strobes and the error flag
  typedef struct packed {
    logic cfg;
    logic selpol;
    logic cmd;
    logic restart;
    logic status;
    logic active;
  } ptc_rsel_t;

  // an unaligned or out-of-range address matches no field, so it lands as an error
  function automatic ptc_rsel_t reg_decode(input logic [PTC_ADDR_W-1:0] addr);
    ptc_rsel_t hit;
    hit = '0;
    hit.cfg = (addr == PTC_OFF_CFG);
    hit.selpol = (addr == PTC_OFF_SELPOL);
    hit.cmd = (addr == PTC_OFF_CMD);
    hit.restart = (addr == PTC_OFF_RESTART);
    hit.status = (addr == PTC_OFF_STATUS);
    hit.active = (addr == PTC_OFF_ACTIVE);
    return hit;
  endfunction

  // =====================================================================
  // apb decode; writes land on the access edge only
  ptc_rsel_t rsel;
  logic acc_edge;
  logic wr_edge;
  logic setup;
  logic addr_ok;
  logic cfg_wr;
  logic selpol_wr;

  assign rsel = reg_decode(paddr);
  assign setup = psel & ~penable;
  assign acc_edge = psel & penable & st_ff.pready;
  // the error flag of the access blocks the write, so an unmapped word changes nothing
  assign wr_edge = acc_edge & pwrite & ~st_ff.pslverr;
  assign addr_ok = |rsel;
  assign cfg_wr = wr_edge & rsel.cfg;
  assign selpol_wr = wr_edge & rsel.selpol;

  // =====================================================================
  // serial command strobes from the command register
  logic cmd_wr;
  logic cmd_stop;
  logic cmd_start;
  logic cmd_step_start;
  logic cmd_cancel;
  logic restart_wr;
  logic [PTC_STEP_W-1:0] cmd_step;

  assign cmd_wr = wr_edge & rsel.cmd;
  assign cmd_stop = cmd_wr & pwdata[PTC_CMD_STOP_POS];
  assign cmd_start = cmd_wr & pwdata[PTC_CMD_START_POS];
  assign cmd_step_start = cmd_wr & pwdata[PTC_CMD_STEP_START_POS];
  assign cmd_cancel = cmd_wr & pwdata[PTC_CMD_CANCEL_POS];
  assign cmd_step = pwdata[PTC_CMD_STEP_POS +: PTC_STEP_W];
  assign restart_wr = wr_edge & rsel.restart & pwdata[PTC_RESTART_POS];

  // =====================================================================
  // conditioning of the wired inputs
  logic wired_mode0;
  logic wired_run;
  logic wired_cancel;
  logic [PTC_STEP_W-1:0] wired_step;

  always_comb begin
    // polarity 3 selects program mode never, which is exactly the jog-mode force
    wired_mode0 = pol_level(mode_pol, mode_c);
    // run and cancel code 3 acts as code 2, so an unused code never starts or cancels
    unique case (run_pol)
      PTC_POL_CLOSED: wired_run = run_c;
      PTC_POL_OPEN: wired_run = ~run_c;
      default: wired_run = 1'b0;
    endcase
    // edges only count once the synchroniser holds real samples
    unique case (cancel_pol)
      PTC_POL_CLOSED: wired_cancel = st_ff.primed & cancel_c & ~st_ff.cancel_prev;
      PTC_POL_OPEN: wired_cancel = st_ff.primed & ~cancel_c & st_ff.cancel_prev;
      default: wired_cancel = 1'b0;
    endcase
    // unused step bits stay zero when fewer select inputs are fitted
    wired_step = '0;
    for (int i = 0; i < SEL_COUNT; i++) begin
      wired_step[i] = pol_level(st_ff.selpol_act[2*i +: 2], sel_c[i]);
    end
  end

  // =====================================================================
  // next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.cancel_prev = cancel_c;
    nxt_st.primed = sif.clean_vld;
    nxt_st.cancel_pulse = 1'b0;

    // serial commands: cancel beats stop, stop beats start
    if (cmd_cancel) begin
      nxt_st.serial_own = 1'b1;
      nxt_st.serial_run = 1'b0;
      nxt_st.serial_step_vld = 1'b0;
    end else if (cmd_stop) begin
      nxt_st.serial_own = 1'b1;
      nxt_st.serial_run = 1'b0;
    end else if (cmd_step_start) begin
      nxt_st.serial_own = 1'b1;
      nxt_st.serial_run = 1'b1;
      nxt_st.serial_step_vld = 1'b1;
      nxt_st.serial_step = cmd_step;
    end else if (cmd_start) begin
      nxt_st.serial_own = 1'b1;
      nxt_st.serial_run = 1'b1;
    end

    // settings only steer the logic after a restart; the restart also hands control back
    if (restart_wr) begin
      nxt_st.cfg_act = st_ff.cfg_shadow;
      nxt_st.selpol_act = st_ff.selpol_shadow;
      nxt_st.serial_own = 1'b0;
      nxt_st.serial_run = 1'b0;
      nxt_st.serial_step_vld = 1'b0;
      nxt_st.primed = 1'b0;
    end

    // mode and run follow the serial path once software has taken over; step does once a step was commanded
    if (st_ff.serial_own) begin
      nxt_st.mode0 = 1'b1;
      nxt_st.run = st_ff.serial_run;
      nxt_st.step = st_ff.serial_step_vld ? st_ff.serial_step : wired_step;
    end else begin
      nxt_st.mode0 = wired_mode0;
      nxt_st.run = wired_run;
      nxt_st.step = wired_step;
    end
    nxt_st.cancel_pulse = wired_cancel | cmd_cancel;
    // a cancel drops the run level in the same cycle as the pulse
    if (wired_cancel | cmd_cancel) begin
      nxt_st.run = 1'b0;
    end

    // shadow setting writes
    if (cfg_wr) begin
      nxt_st.cfg_shadow = pwdata[PTC_CFG_W-1:0];
    end
    if (selpol_wr) begin
      nxt_st.selpol_shadow = pwdata[PTC_SELPOL_W-1:0];
    end

    // apb answer: ready rises for the access phase after each setup, unmapped flags error
    nxt_st.pready = 1'b0;
    nxt_st.pslverr = 1'b0;
    if (setup) begin
      nxt_st.pready = 1'b1;
      nxt_st.pslverr = ~addr_ok;
      nxt_st.prdata = '0;
      if (!pwrite) begin
        unique case (paddr)
          PTC_OFF_CFG: nxt_st.prdata[PTC_CFG_W-1:0] = st_ff.cfg_shadow;
          PTC_OFF_SELPOL: nxt_st.prdata[PTC_SELPOL_W-1:0] = st_ff.selpol_shadow;
          PTC_OFF_STATUS: begin
            nxt_st.prdata[PTC_ST_MODE0_POS] = st_ff.mode0;
            nxt_st.prdata[PTC_ST_RUN_POS] = st_ff.run;
            nxt_st.prdata[PTC_ST_SERIAL_POS] = st_ff.serial_own;
            nxt_st.prdata[PTC_ST_STEPVLD_POS] = st_ff.serial_step_vld;
            nxt_st.prdata[PTC_ST_STEP_POS +: PTC_STEP_W] = st_ff.step;
            nxt_st.prdata[PTC_ST_RAW_POS +: PTC_RAW_W] = sif.clean;
          end
          PTC_OFF_ACTIVE: begin
            nxt_st.prdata[PTC_CFG_W-1:0] = st_ff.cfg_act;
            nxt_st.prdata[PTC_ST_RAW_POS +: PTC_SELPOL_W] = st_ff.selpol_act;
          end
          default: nxt_st.prdata = '0;
        endcase
      end
    end else if (psel && penable && !st_ff.pready) begin
      // access without our setup seen: answer one cycle late rather than hang
      nxt_st.pready = 1'b1;
      nxt_st.pslverr = st_ff.pslverr;
    end
  end

  // =====================================================================
  // state register; reset loads the default code of every setting field
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff <= '0;
      st_ff.cfg_shadow <= PTC_CFG_RST;
      st_ff.selpol_shadow <= PTC_SELPOL_RST;
      st_ff.cfg_act <= PTC_CFG_RST;
      st_ff.selpol_act <= PTC_SELPOL_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // =====================================================================
  // outputs straight from the state register
  // status reads copy these same flops in the setup cycle, so the read data shows the pins as they stood one cycle before ready
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign prdata = st_ff.prdata;
  assign program_mode = st_ff.mode0;
  assign sequence_run = st_ff.run;
  assign sequence_cancel_pulse = st_ff.cancel_pulse;
  assign sequence_step_number = st_ff.step;
endmodule
`default_nettype wire

// [core/ptc_pkg.sv]
// package: register map, field layout, reset values and setting codes of the input conditioner
package ptc_pkg;

  // =====================================================================
  // bus and register map
  localparam int unsigned PTC_ADDR_W = 8;
  localparam int unsigned PTC_DATA_W = 32;
  localparam logic [7:0] PTC_OFF_CFG = 8'h00;
  localparam logic [7:0] PTC_OFF_SELPOL = 8'h04;
  localparam logic [7:0] PTC_OFF_CMD = 8'h08;
  localparam logic [7:0] PTC_OFF_RESTART = 8'h0C;
  localparam logic [7:0] PTC_OFF_STATUS = 8'h10;
  localparam logic [7:0] PTC_OFF_ACTIVE = 8'h14;

  // =====================================================================
  // configuration register fields (each setting is two bits)
  localparam int unsigned PTC_CFG_MODE_POS = 0;
  localparam int unsigned PTC_CFG_RUN_POS = 2;
  localparam int unsigned PTC_CFG_CANCEL_POS = 4;
  localparam int unsigned PTC_CFG_W = 6;
  localparam logic [5:0] PTC_CFG_RST = 6'h00;
  localparam int unsigned PTC_SELPOL_W = 16;
  localparam logic [15:0] PTC_SELPOL_RST = 16'h0000;

  // =====================================================================
  // command register fields
  localparam int unsigned PTC_CMD_STOP_POS = 0;
  localparam int unsigned PTC_CMD_START_POS = 1;
  localparam int unsigned PTC_CMD_STEP_START_POS = 2;
  localparam int unsigned PTC_CMD_CANCEL_POS = 3;
  localparam int unsigned PTC_CMD_STEP_POS = 8;
  localparam int unsigned PTC_RESTART_POS = 0;

  // =====================================================================
  // status register fields
  localparam int unsigned PTC_ST_MODE0_POS = 0;
  localparam int unsigned PTC_ST_RUN_POS = 1;
  localparam int unsigned PTC_ST_SERIAL_POS = 2;
  localparam int unsigned PTC_ST_STEPVLD_POS = 3;
  localparam int unsigned PTC_ST_STEP_POS = 8;
  localparam int unsigned PTC_ST_RAW_POS = 16;

  // =====================================================================
  // step number and input synchroniser
  localparam int unsigned PTC_STEP_W = 8;
  localparam int unsigned PTC_SYNC_STAGES = 2;
  localparam int unsigned PTC_RAW_W = 11;

  // =====================================================================
  // two-bit setting codes
  localparam logic [1:0] PTC_POL_CLOSED = 2'h0;
  localparam logic [1:0] PTC_POL_OPEN = 2'h1;
  localparam logic [1:0] PTC_POL_FORCE_ON = 2'h2;
  localparam logic [1:0] PTC_POL_FORCE_OFF = 2'h3;

endpackage

// [core/ptc_sync.sv]
// module: multi-stage synchroniser for the contact inputs with a filled flag
`timescale 1ns/10ps
`default_nettype none
module ptc_sync #(
  parameter int unsigned WIDTH = 11,
  parameter int unsigned STAGES = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // levels in and out
  ptc_sync_if.sync_mp sif
);
  import ptc_pkg::*;

  typedef struct packed {
    logic [STAGES-1:0][WIDTH-1:0] stage;
    logic [STAGES-1:0] fill;
  } ptc_sync_state_t;

  ptc_sync_state_t st_ff;
  ptc_sync_state_t nxt_st;

  // =====================================================================
  // elaboration checks
  if (STAGES < 2) begin : g_bad_stages
    $error("ptc_sync needs at least two stages");
  end

  // =====================================================================
  // shift chain; stage 0 is read only by stage 1
  always_comb begin
    nxt_st = st_ff;
    nxt_st.stage[0] = sif.raw;
    for (int i = 1; i < STAGES; i++) begin
      nxt_st.stage[i] = st_ff.stage[i-1];
    end
    nxt_st.fill = {st_ff.fill[STAGES-2:0], 1'b1};
  end

  // =====================================================================
  // state register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sif.clean = st_ff.stage[STAGES-1];
  // the flag only rises once real samples reach the output, so no false edge after reset
  assign sif.clean_vld = st_ff.fill[STAGES-1];
endmodule
`default_nettype wire

// [core/ptc_sync_if.sv]
// interface: raw contact levels into the synchroniser and the clean levels back
`timescale 1ns/10ps
`default_nettype none
interface ptc_sync_if #(
  parameter int unsigned WIDTH = 11
);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] clean;
  logic clean_vld;

  // =====================================================================
  // the synchroniser side and the user side
  modport sync_mp (input raw, output clean, output clean_vld);
  modport user_mp (output raw, input clean, input clean_vld);
endinterface
`default_nettype wire

// [dv/ptc_cond_assertions.sv]
// checker: port-level timing checks of the input conditioner
`timescale 1ns/10ps
`default_nettype none
module ptc_cond_chk #(
  parameter int unsigned SEL_COUNT = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ptc_pkg::PTC_ADDR_W-1:0] paddr,
  input wire logic [ptc_pkg::PTC_DATA_W-1:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [ptc_pkg::PTC_DATA_W-1:0] prdata,
  // contacts
  input wire logic mode_select_in,
  input wire logic run_halt_in,
  input wire logic sequence_cancel_in,
  input wire logic [SEL_COUNT-1:0] step_select_in,
  // conditioned outputs
  input wire logic program_mode,
  input wire logic sequence_run,
  input wire logic sequence_cancel_pulse,
  input wire logic [ptc_pkg::PTC_STEP_W-1:0] sequence_step_number
);
  import ptc_pkg::*;
  // =====================================================================
  // recent history: a cancel pulse needs a contact edge or a command write
  logic [6:0] cin_ff;
  logic [2:0] cmd_ff;
  logic cmd_wr;
  assign cmd_wr = psel && penable && pwrite && (paddr == PTC_OFF_CMD);
  always_ff @(posedge clk) begin
    cin_ff <= {cin_ff[5:0], sequence_cancel_in};
    cmd_ff <= {cmd_ff[1:0], cmd_wr};
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // =====================================================================
  // bus and conditioned outputs
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  property p_ready_one; pready |=> !pready; endproperty
  a_ready_one: assert property (p_ready_one) else $error("ready too long");
  property p_idle; !psel |=> !pready; endproperty
  a_idle: assert property (p_idle) else $error("ready without select");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_unmapped; psel && !penable && paddr > 8'h14 |=> pslverr && prdata == 0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
  property p_pulse_one; sequence_cancel_pulse |=> !sequence_cancel_pulse; endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("cancel pulse too long");
  property p_pulse_cause;
    sequence_cancel_pulse |-> (|(cin_ff[6:1] ^ cin_ff[5:0])) || (|cmd_ff);
  endproperty
  a_pulse_cause: assert property (p_pulse_cause) else $error("cancel without cause");
  property p_pulse_run; sequence_cancel_pulse |-> !sequence_run; endproperty
  a_pulse_run: assert property (p_pulse_run) else $error("run during cancel");
  property p_rst;
    disable iff (1'b0) sys_rst |=> !program_mode && !sequence_run && sequence_step_number == 0;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared");
  // main scenarios
  c_pulse: cover property (sequence_cancel_pulse);
  c_err: cover property (pready && pslverr);
  c_run: cover property (sequence_run && program_mode);
endmodule
bind ptc_cond ptc_cond_chk #(.SEL_COUNT(SEL_COUNT)) i_chk (.clk, .sys_rst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata, .mode_select_in, .run_halt_in,
  .sequence_cancel_in, .step_select_in, .program_mode, .sequence_run, .sequence_cancel_pulse,
  .sequence_step_number);
`default_nettype wire

// [dv/ptc_host_model.sv]
// model: host controller driving the discrete contacts of the conditioner
`timescale 1ns/10ps
`default_nettype none
module ptc_host_model (
  // clock
  input wire logic clk,
  // wanted levels {select[7:0], cancel, run, mode}, 1 = closed
  input wire logic [10:0] want,
  // contact lines
  output logic [10:0] contact
);
  // =====================================================================
  // relay contacts move just after an edge, all together, never mid-cycle
  initial contact = 11'h000;
  always @(posedge clk) begin
    contact <= want;
  end
endmodule
`default_nettype wire

// [dv/tb_ptc_cond.sv]
// testbench: apb-driven checks of the input conditioner
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module tb_ptc_cond;
  import ptc_pkg::*;
  // =====================================================================
  // clock, reset, bus and contacts
  logic clk = 0;
  logic sys_rst = 1;
  logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [10:0] want = 11'h000, contact;
  logic program_mode, sequence_run, sequence_cancel_pulse;
  logic [7:0] sequence_step_number;
  logic [7:0] exs [4] = '{8'hA5, 8'h5A, 8'hFF, 8'h00};
  int err_count = 0, samples_checked = 0, cyc = 0, pulses = 0, p0, p1;
  always #50 clk = ~clk;
  ptc_host_model i_host (.clk(clk), .want(want), .contact(contact));
  ptc_cond i_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .mode_select_in(contact[0]), .run_halt_in(contact[1]),
    .sequence_cancel_in(contact[2]), .step_select_in(contact[10:3]),
    .program_mode(program_mode), .sequence_run(sequence_run),
    .sequence_cancel_pulse(sequence_cancel_pulse),
    .sequence_step_number(sequence_step_number));
  // cycle limit and pulse count; a hang ends the run as a mismatch
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (sequence_cancel_pulse === 1'b1) pulses <= pulses + 1;
    if (cyc == 5000) begin
      err_count++;
      stop_test();
    end
  end
  // =====================================================================
  // tasks
  task stop_test;
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one apb transfer; holds the request until ready is seen at an edge
  // a wait with no answer is ended only by the bench timeout, which counts a mismatch
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK("read", e, rd)
  endtask
  // new settings only count once restart is written
  task setup(input logic [31:0] cfg, input logic [31:0] sp);
    apb(1'b1, PTC_OFF_CFG, cfg);
    apb(1'b1, PTC_OFF_SELPOL, sp);
    apb(1'b1, PTC_OFF_RESTART, 32'h0000_0001);
    repeat (8) @(posedge clk);
  endtask
  task drive(input logic [10:0] v);
    @(posedge clk);
    want <= v;
    repeat (6) @(posedge clk);
  endtask
  // =====================================================================
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("mode_rst", 1'b0, program_mode)
    rchk(PTC_OFF_CFG, 32'h0000_0000);
    rchk(8'h20, 32'h0000_0000);
    `CHK("slverr", 1'b1, er)
    for (int s = 0; s < 4; s++) for (int c = 0; c < 2; c++) begin
      setup(s, 0);
      drive(c);
      `CHK("mode", (s == 2) || (s == 0 && c == 1) || (s == 1 && c == 0), program_mode)
      setup(s << 2 | 2, 0);
      drive(c << 1);
      `CHK("run", (s == 0 && c == 1) || (s == 1 && c == 0), sequence_run)
    end
    for (int s = 0; s < 4; s++) begin
      setup(s << 4 | 2, 0);
      drive(0);
      p0 = pulses;
      drive(11'h004);
      p1 = pulses;
      drive(0);
      `CHK("rise", (s == 0) ? 1 : 0, p1 - p0)
      `CHK("fall", (s == 1) ? 1 : 0, pulses - p1)
      setup(2, {8{s[1:0]}});
      drive({8'hA5, 3'b000});
      `CHK("step", exs[s], sequence_step_number)
    end
    setup(2, 16'h4000);
    `CHK("step_mix", 8'h25, sequence_step_number)
    rchk(PTC_OFF_ACTIVE, 32'h4000_0002);
    setup(0, 0);
    drive({8'h3C, 3'b000});
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, PTC_OFF_CMD, {16'h0000, k ? 8'hFF : 8'h00, 8'h04});
      repeat (3) @(posedge clk);
      `CHK("cmd_step", k ? 8'hFF : 8'h00, sequence_step_number)
      `CHK("cmd_run", 1'b1, sequence_run)
      `CHK("cmd_mode", 1'b1, program_mode)
    end
    apb(1'b1, PTC_OFF_CMD, 32'h0000_0001);
    repeat (3) @(posedge clk);
    `CHK("stop", 1'b0, sequence_run)
    apb(1'b1, PTC_OFF_CMD, 32'h0000_0002);
    repeat (3) @(posedge clk);
    `CHK("start", 1'b1, sequence_run)
    p0 = pulses;
    apb(1'b1, PTC_OFF_CMD, 32'h0000_0008);
    repeat (3) @(posedge clk);
    `CHK("cancel", 1, pulses - p0)
    apb(1'b0, PTC_OFF_STATUS, 32'h0000_0000);
    `CHK("serial", 1'b1, rd[2])
    stop_test();
  end
endmodule
`default_nettype wire
